/* plc_arith_cfg.svh */
/*
 Constants of the binary/BCD arithmetic unit: register offsets, command
 field positions, depths, event bits and BCD digit limits. Included by the package.
 // Operation
 // - sub_bin16: accumulator minus 16-bit operand
 // - 16-bit subtract borrow sets borrow16 flag
 // - sub_bin32: accumulator minus 32-bit operand
 // - 32-bit subtract borrow sets borrow32 flag
 // - mul_bin16: 16x16 product into accumulator
 // - div_bin16: quotient to accumulator, remainder stacked
 // - Divide operand unusable sets operand-range flag
 // - Zero result sets zero flag
 // - Negative result sets negative flag
 // - Flags hold until next affecting instruction
 // - inc_bin_word: memory word plus one
 // - dec_bin_word: memory word minus one
 // - add_bcd_bitrange: accumulator plus 1-32 bit BCD
 // - 32-bit add carry sets carry32 flag
 // - Wrong signed result sign sets sign-error flag
 // - Non-BCD operand sets bad-BCD flag
 // - Invalid pointer target sets bad-pointer flag
 // - Accumulator load pushes old value on stack
*/
`ifndef PLC_ARITH_CFG_SVH
`define PLC_ARITH_CFG_SVH
`define ADR_ACC    8'h00
`define ADR_OPD    8'h04
`define ADR_CMD    8'h08
`define ADR_STK    8'h0C
`define ADR_FLG    8'h10
`define ADR_STS    8'h14
`define ADR_MSK    8'h18
`define DMEM_SEL   2'h1
`define OP_POS     0
`define SRC_POS    4
`define ADDR_POS   8
`define CNT_POS    16
`define CNT_FULL   6'h20
`define MEM_AW     4
`define MEM_DEPTH  16
`define STK_DEPTH  8
`define IRQ_W      5
`define EV_DONE    0
`define EV_RANGE   1
`define EV_BCD     2
`define EV_PTR     3
`define EV_SIGN    4
`define BCD_DIGITS 8
`define BCD_NINE   5'h09
`define BCD_ADJ    5'h06
`endif

/* plc_arith_pkg.sv */
/*
 Types of the arithmetic unit: opcodes, operand sources, flag set and
 the single packed state record. Assumes plc_arith_cfg.svh is reachable.
*/
`include "plc_arith_cfg.svh"
package plc_arith_pkg;
    typedef enum logic [3:0] {
        OP_NONE          = 4'b0000,
        OP_SUB_BIN16     = 4'b0001,
        OP_SUB_BIN32     = 4'b0010,
        OP_MUL_BIN16     = 4'b0011,
        OP_DIV_BIN16     = 4'b0100,
        OP_INC_BIN_WORD  = 4'b0101,
        OP_DEC_BIN_WORD  = 4'b0110,
        OP_ADD_BCD_RANGE = 4'b0111
    } op_t;
    typedef enum logic [1:0] {
        SRC_CONST = 2'b00,
        SRC_MEM   = 2'b01,
        SRC_PTR   = 2'b10
    } src_t;
    typedef struct packed {
        logic badPointerFlag;
        logic operandRangeFlag;
        logic badBcdFlag;
        logic signErrorFlag;
        logic negativeFlag;
        logic carry32Flag;
        logic borrow32Flag;
        logic borrow16Flag;
        logic zeroFlag;
    } flags_t;
    typedef struct packed {
        logic                               ack;
        logic [31:0]                        dat;
        logic                               irq;
        logic [31:0]                        acc;
        logic [31:0]                        opd;
        logic [31:0]                        cmd;
        logic [`STK_DEPTH-1:0][31:0]        stack;
        flags_t                             flags;
        logic [`IRQ_W-1:0]                  sts;
        logic [`IRQ_W-1:0]                  msk;
        logic [`MEM_DEPTH-1:0][15:0]        mem;
    } state_t;
endpackage : plc_arith_pkg

/* plc_binary_bcd_arith_unit.sv */
/*
 Arithmetic execution unit: binary subtract, multiply, divide,
 memory word increment/decrement and BCD add of a bit range, with
 status flags, accumulator stack and a local data memory window.
 Assumes a classic Wishbone master on core_clk; one command per write.
*/
`timescale 1ns/1ps
module plc_binary_bcd_arith_unit
    import plc_arith_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Interrupt
    output logic             irq
);

    state_t                 s;
    state_t                 n;
    logic                   req;
    logic                   wr;
    logic                   fire;
    logic [31:0]            cmdNew;
    logic [31:0]            wtmp;
    op_t                    op;
    src_t                   src;
    logic [5:0]             cnt;
    logic [`MEM_AW-1:0]     adr;
    logic [`MEM_AW-1:0]     ea;
    logic [15:0]            ptr;
    logic [15:0]            w16;
    logic [15:0]            o16;
    logic [31:0]            o32;
    logic [31:0]            mask;
    logic                   ptrBad;
    logic [16:0]            d17;
    logic [32:0]            d33;
    logic [32:0]            bcd;
    logic [`IRQ_W-1:0]      ev;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i+:8] = nw[8*i+:8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic bcdValid(input logic [31:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < `BCD_DIGITS; i++) begin
            if ({1'b0, v[4*i+:4]} > `BCD_NINE) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : bcdValid

    // Digit-serial decimal add, carry out in bit 32
    function automatic logic [32:0] bcdAdd(input logic [31:0] a, input logic [31:0] b);
        logic [4:0]  d;
        logic        c;
        logic [31:0] r;
        c = 1'b0;
        r = 32'h0000_0000;
        for (int i = 0; i < `BCD_DIGITS; i++) begin
            d = {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + {4'h0, c};
            c = (d > `BCD_NINE);
            if (c) begin
                d = d + `BCD_ADJ;
            end
            r[4*i+:4] = d[3:0];
        end
        return {c, r};
    endfunction : bcdAdd

    always_comb begin
        n      = s;
        n.ack  = 1'b0;
        ev     = '0;
        wtmp   = 32'h0000_0000;
        req    = cyc_i & stb_i & ~s.ack;
        wr     = req & we_i;
        cmdNew = merge(s.cmd, dat_i, sel_i);
        fire   = wr && (adr_i == `ADR_CMD);
        op     = op_t'(cmdNew[`OP_POS+:4]);
        src    = src_t'(cmdNew[`SRC_POS+:2]);
        cnt    = cmdNew[`CNT_POS+:6];
        adr    = cmdNew[`ADDR_POS+:`MEM_AW];
        ptr    = s.mem[adr];
        ptrBad = (src == SRC_PTR) && (|ptr[15:`MEM_AW] ||
                 (op == OP_SUB_BIN32 && &ptr[`MEM_AW-1:0]));
        ea     = (src == SRC_PTR) ? ptr[`MEM_AW-1:0] : adr;
        w16    = s.mem[ea];
        o16    = (src == SRC_CONST) ? s.opd[15:0] : w16;
        o32    = (src == SRC_CONST) ? s.opd : {s.mem[ea + 1'b1], w16};
        mask   = (cnt >= `CNT_FULL) ? 32'hFFFF_FFFF : ((32'h0000_0001 << cnt) - 32'h0000_0001);
        d17    = {1'b0, s.acc[15:0]} - {1'b0, o16};
        d33    = {1'b0, s.acc} - {1'b0, o32};
        bcd    = bcdAdd(s.acc, s.opd & mask);
        if (req) begin
            n.ack = 1'b1;
            n.dat = 32'h0000_0000;
        end
        if (req && !we_i) begin
            case (adr_i)
                `ADR_ACC: n.dat = s.acc;
                `ADR_OPD: n.dat = s.opd;
                `ADR_CMD: n.dat = s.cmd;
                `ADR_STK: n.dat = s.stack[0];
                `ADR_FLG: n.dat = {23'h000000, s.flags};
                `ADR_STS: begin
                    n.dat = {27'h0000000, s.sts};
                    n.sts = '0;
                end
                `ADR_MSK: n.dat = {27'h0000000, s.msk};
                default: begin
                    if (adr_i[7:6] == `DMEM_SEL) begin
                        n.dat = {16'h0000, s.mem[adr_i[5:2]]};
                    end
                end
            endcase
        end
        if (wr) begin
            case (adr_i)
                `ADR_ACC: begin
                    for (int i = `STK_DEPTH - 1; i > 0; i--) begin
                        n.stack[i] = s.stack[i-1];
                    end
                    n.stack[0] = s.acc;
                    n.acc = merge(s.acc, dat_i, sel_i);
                end
                `ADR_OPD: n.opd = merge(s.opd, dat_i, sel_i);
                `ADR_CMD: n.cmd = cmdNew;
                `ADR_MSK: begin
                    wtmp  = merge({27'h0000000, s.msk}, dat_i, sel_i);
                    n.msk = wtmp[`IRQ_W-1:0];
                end
                default: begin
                    if (adr_i[7:6] == `DMEM_SEL) begin
                        wtmp = merge({16'h0000, s.mem[adr_i[5:2]]}, dat_i, sel_i);
                        n.mem[adr_i[5:2]] = wtmp[15:0];
                    end
                end
            endcase
        end
        if (fire) begin
            ev[`EV_DONE] = 1'b1;
            if (ptrBad && op != OP_ADD_BCD_RANGE) begin
                n.flags.badPointerFlag = 1'b1;
                ev[`EV_PTR]            = 1'b1;
            end else begin
                if (src == SRC_PTR && op != OP_ADD_BCD_RANGE) begin
                    n.flags.badPointerFlag = 1'b0;
                end
                case (op)
                    OP_SUB_BIN16: begin
                        n.acc                 = {16'h0000, d17[15:0]};
                        n.flags.borrow16Flag  = d17[16];
                        n.flags.zeroFlag      = (d17[15:0] == 16'h0000);
                        n.flags.negativeFlag  = d17[15];
                        n.flags.signErrorFlag = (s.acc[15] ^ o16[15]) & (d17[15] ^ s.acc[15]);
                    end
                    OP_SUB_BIN32: begin
                        n.acc                 = d33[31:0];
                        n.flags.borrow32Flag  = d33[32];
                        n.flags.zeroFlag      = (d33[31:0] == 32'h0000_0000);
                        n.flags.negativeFlag  = d33[31];
                        n.flags.signErrorFlag = (s.acc[31] ^ o32[31]) & (d33[31] ^ s.acc[31]);
                    end
                    OP_MUL_BIN16: begin
                        n.acc                = {16'h0000, s.acc[15:0]} * {16'h0000, o16};
                        n.flags.zeroFlag     = (n.acc == 32'h0000_0000);
                        n.flags.negativeFlag = n.acc[31];
                    end
                    OP_DIV_BIN16: begin
                        n.flags.operandRangeFlag = (o16 == 16'h0000);
                        ev[`EV_RANGE]            = (o16 == 16'h0000);
                        if (o16 != 16'h0000) begin
                            n.acc                = s.acc / {16'h0000, o16};
                            n.stack[0]           = s.acc % {16'h0000, o16};
                            n.flags.zeroFlag     = (n.acc == 32'h0000_0000);
                            n.flags.negativeFlag = n.acc[31];
                        end
                    end
                    OP_INC_BIN_WORD: begin
                        n.mem[ea]        = w16 + 16'h0001;
                        n.flags.zeroFlag = (w16 == 16'hFFFF);
                    end
                    OP_DEC_BIN_WORD: begin
                        n.mem[ea]        = w16 - 16'h0001;
                        n.flags.zeroFlag = (w16 == 16'h0001);
                    end
                    OP_ADD_BCD_RANGE: begin
                        n.flags.badBcdFlag = !bcdValid(s.acc) || !bcdValid(s.opd & mask);
                        ev[`EV_BCD]        = n.flags.badBcdFlag;
                        n.flags.signErrorFlag = 1'b0;
                        if (!n.flags.badBcdFlag) begin
                            n.acc                = bcd[31:0];
                            n.flags.carry32Flag  = bcd[32];
                            n.flags.zeroFlag     = (bcd[31:0] == 32'h0000_0000);
                            n.flags.negativeFlag = bcd[31];
                        end
                    end
                    default: ;
                endcase
                ev[`EV_SIGN] = n.flags.signErrorFlag & ~s.flags.signErrorFlag;
            end
        end
        // Set wins over read-clear
        n.sts = n.sts | ev;
        n.irq = |(n.sts & n.msk);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign dat_o = s.dat;
    assign ack_o = s.ack;
    assign irq   = s.irq;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_run(op_t o);
        fire && op == o && src == SRC_CONST;
    endsequence
    sequence s_mem(op_t o);
        fire && op == o && src == SRC_MEM;
    endsequence

    property p_sub16;
        s_run(OP_SUB_BIN16) |=> s.acc[15:0] == 16'($past(s.acc[15:0]) - $past(s.opd[15:0]));
    endproperty
    a_sub16: assert property (p_sub16) else $error("sub16 result wrong");

    property p_borrow16;
        s_run(OP_SUB_BIN16) |=> s.flags.borrow16Flag == ($past(s.opd[15:0]) > $past(s.acc[15:0]));
    endproperty
    a_borrow16: assert property (p_borrow16) else $error("borrow16 wrong");

    property p_sub32;
        s_run(OP_SUB_BIN32) |=> s.acc == $past(s.acc) - $past(s.opd);
    endproperty
    a_sub32: assert property (p_sub32) else $error("sub32 result wrong");

    property p_borrow32;
        s_run(OP_SUB_BIN32) |=> s.flags.borrow32Flag == ($past(s.opd) > $past(s.acc));
    endproperty
    a_borrow32: assert property (p_borrow32) else $error("borrow32 wrong");

    property p_mul;
        s_run(OP_MUL_BIN16) |=> s.acc == $past(s.acc[15:0]) * $past(s.opd[15:0]);
    endproperty
    a_mul: assert property (p_mul) else $error("product wrong");

    property p_div;
        s_run(OP_DIV_BIN16) ##0 (s.opd[15:0] != 16'h0000) |=>
            s.stack[0] == $past(s.acc) % {16'h0000, $past(s.opd[15:0])};
    endproperty
    a_div: assert property (p_div) else $error("remainder wrong");

    property p_range;
        s_run(OP_DIV_BIN16) ##0 (s.opd[15:0] == 16'h0000) |=>
            s.flags.operandRangeFlag && s.sts[`EV_RANGE] && $stable(s.acc) && $stable(s.stack[0])
            ##1 (s.irq || !s.msk[`EV_RANGE]);
    endproperty
    a_range: assert property (p_range) else $error("range flag missing");

    property p_zero;
        fire && src == SRC_CONST && op inside {OP_SUB_BIN32, OP_MUL_BIN16} |=>
            s.flags.zeroFlag == (s.acc == 32'h0000_0000);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_neg;
        fire && src == SRC_CONST && op inside {OP_SUB_BIN32, OP_MUL_BIN16} |=>
            s.flags.negativeFlag == s.acc[31];
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag wrong");

    property p_hold;
        !fire |=> $stable(s.flags);
    endproperty
    a_hold: assert property (p_hold) else $error("flags changed idle");

    property p_inc;
        s_mem(OP_INC_BIN_WORD) |=> s.mem[$past(ea)] == 16'($past(w16) + 16'h0001);
    endproperty
    a_inc: assert property (p_inc) else $error("increment wrong");

    property p_dec;
        s_mem(OP_DEC_BIN_WORD) |=>
            s.mem[$past(ea)] == 16'($past(w16) - 16'h0001) && s.flags.zeroFlag == (s.mem[$past(ea)] == 16'h0000);
    endproperty
    a_dec: assert property (p_dec) else $error("decrement wrong");

    property p_badbcd;
        fire && op == OP_ADD_BCD_RANGE && (!bcdValid(s.acc) || !bcdValid(s.opd & mask)) |=>
            s.flags.badBcdFlag && $stable(s.acc);
    endproperty
    a_badbcd: assert property (p_badbcd) else $error("bad BCD not caught");

    property p_ptr;
        fire && ptrBad && op != OP_ADD_BCD_RANGE |=> s.flags.badPointerFlag && $stable(s.acc);
    endproperty
    a_ptr: assert property (p_ptr) else $error("bad pointer not caught");

    property p_push;
        wr && adr_i == `ADR_ACC |=> s.stack[0] == $past(s.acc) && s.stack[1] == $past(s.stack[0]);
    endproperty
    a_push: assert property (p_push) else $error("stack push wrong");

endmodule : plc_binary_bcd_arith_unit

/* plc_seq_master.sv */
/*
 Classic Wishbone master standing in for the instruction sequencer.
 Assumes one slave on core_clk that answers every request with ack.
*/
`timescale 1ns/1ps
module plc_seq_master (
    // Clock
    input  wire logic        core_clk,
    // Bus towards the unit
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic [7:0]       adr,
    output logic [3:0]       sel,
    output logic [31:0]      wdat,
    input  wire logic [31:0] rdat,
    input  wire logic        ack
);
    initial begin
        cyc  = 1'b0;
        stb  = 1'b0;
        we   = 1'b0;
        adr  = 8'h00;
        sel  = 4'h0;
        wdat = 32'h00000000;
    end

    // Request held until ack is sampled, then released for a cycle
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hF;
        wdat <= d;
        do @(posedge core_clk); while (ack !== 1'b1);
        q = rdat;
        cyc  <= 1'b0;
        stb  <= 1'b0;
        we   <= 1'b0;
        wdat <= ~d;
    endtask : access
endmodule : plc_seq_master

/* plc_binary_bcd_arith_unit_tb.sv */
/*
 Self-checking bench of the arithmetic unit: random binary operations,
 memory, pointer, BCD, stack and interrupt corners.
 Assumes the master model drives the bus and a 125 MHz core_clk.
*/
`timescale 1ns/1ps
module plc_binary_bcd_arith_unit_tb;
    import plc_arith_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        cyc, stb, we, ack, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, rv, a, b, e, r, m, ef;
    logic [33:0] bx;
    logic [3:0]  op;
    integer      seed = 32'h54B0;
    integer      failCount = 0;
    integer      totalChecks = 0;
    integer      cycles = 0;
    integer      i;
    logic        zf;
    logic [31:0] bA [5] = '{32'h19, 32'h99999999, 32'h19, 32'h19, 32'h2B};
    logic [31:0] bB [5] = '{32'h23, 32'h1, 32'h1A, 32'hF23, 32'h1};
    logic [5:0]  bC [5] = '{6'd8, 6'd32, 6'd8, 6'd8, 6'd8};
    logic [7:0]  rstAdr [6] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h30};

    always #4 core_clk = ~core_clk;

    plc_seq_master plc_seq_master_inst (.core_clk(core_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .sel(sel), .wdat(wdat), .rdat(rdat), .ack(ack));
    plc_binary_bcd_arith_unit plc_binary_bcd_arith_unit_inst (.core_clk(core_clk), .rst_n(rst_n), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .irq(irq));

    task automatic conclude;
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failCount = failCount + 1;
            conclude();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks = totalChecks + 1;
        if (seen !== exp) begin
            failCount = failCount + 1;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] q;
        plc_seq_master_inst.access(1'b1, ad, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] ad);
        plc_seq_master_inst.access(1'b0, ad, 32'h0, rv);
    endtask : rd

    // Load accumulator and operand, then issue one command
    task automatic run(input logic [31:0] x, input logic [31:0] y, input logic [3:0] o, input logic [1:0] s,
                       input logic [3:0] ma, input logic [5:0] cnt);
        wr(8'h00, x);
        wr(8'h04, y);
        wr(8'h08, {10'h0, cnt, 4'h0, ma, 2'b00, s, o});
        rd(8'h00);
    endtask : run

    task automatic flags(input logic [31:0] msk, input logic [31:0] exp);
        rd(8'h10);
        check("flags", rv & msk, exp);
    endtask : flags

    // Returns {non-BCD, carry, sum} of a plus the masked bit range
    function automatic logic [33:0] bcdExp(input logic [31:0] x, input logic [31:0] y, input logic [5:0] cnt);
        logic [31:0] s;
        logic [4:0]  dg;
        logic        c, bad;
        if (cnt < 6'd32) y = y & ((32'h1 << cnt) - 32'h1);
        c = 1'b0;
        bad = 1'b0;
        for (int k = 0; k < 8; k++) begin
            bad = bad | (x[k*4+:4] > 4'h9) | (y[k*4+:4] > 4'h9);
            dg = x[k*4+:4] + y[k*4+:4] + c;
            c = dg > 5'h09;
            s[k*4+:4] = c ? 4'(dg - 5'h0A) : dg[3:0];
        end
        return {bad, c, s};
    endfunction : bcdExp

    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rstAdr[j]) begin
            rd(rstAdr[j]);
            check("reset value", rv, 32'h0);
        end
        check("irq after reset", {31'h0, irq}, 32'h0);
        for (i = 0; i < 32; i++) begin
            op = 4'(i % 4 + 1);
            a = $random(seed);
            b = $random(seed);
            if (op != 4'd2) b = b & 32'h0000FFFF;
            if (op == 4'd1 || op == 4'd3) a = a & 32'h0000FFFF;
            if (i < 4) b = (op == 4'd4) ? 32'h1 : a & ((op == 4'd2) ? 32'hFFFFFFFF : 32'hFFFF);
            if (op == 4'd4 && b == 32'h0) b = 32'h7;
            run(a, b, op, 2'b00, 4'h0, 6'd0);
            case (op)
                4'd1: e = {16'h0, a[15:0] - b[15:0]};
                4'd2: e = a - b;
                4'd3: e = a[15:0] * b[15:0];
                default: e = a / b;
            endcase
            r = a % b;
            check("accumulator", rv, e);
            m = 32'h11;
            ef = {27'h0, (op == 4'd1) ? e[15] : e[31], 3'b000, e == 32'h0};
            if (op == 4'd1) begin
                m = 32'h33;
                ef[1] = a[15:0] < b[15:0];
                ef[5] = (a[15] != b[15]) && (e[15] != a[15]);
            end
            if (op == 4'd2) begin
                m = 32'h35;
                ef[2] = a < b;
                ef[5] = (a[31] != b[31]) && (e[31] != a[31]);
            end
            flags(m, ef);
            if (op == 4'd4) begin
                flags(32'h80, 32'h0);
                rd(8'h0C);
                check("remainder", rv, r);
            end
        end
        run(32'h1, 32'h2, 4'd1, 2'b00, 4'h0, 6'd0);
        run(32'h3, 32'h2, 4'd3, 2'b00, 4'h0, 6'd0);
        flags(32'h2, 32'h2);
        wr(8'h00, 32'hAAAA5555);
        run(32'h1234, 32'h0, 4'd4, 2'b00, 4'h0, 6'd0);
        check("divide by zero", rv, 32'h1234);
        flags(32'h80, 32'h80);
        rd(8'h0C);
        check("stack level", rv, 32'hAAAA5555);
        wr(8'h4C, 32'hFFFF);
        wr(8'h08, {20'h0, 4'h3, 4'h1, 4'd5});
        rd(8'h4C);
        check("increment", rv & 32'hFFFF, 32'h0);
        flags(32'h1, 32'h1);
        wr(8'h08, {20'h0, 4'h3, 4'h1, 4'd6});
        rd(8'h4C);
        check("decrement", rv & 32'hFFFF, 32'hFFFF);
        flags(32'h1, 32'h0);
        wr(8'h50, 32'h0001);
        wr(8'h54, 32'h0002);
        run(32'h00030003, 32'h0, 4'd2, 2'b01, 4'h4, 6'd0);
        check("double word operand", rv, 32'h00010002);
        wr(8'h48, 32'h0020);
        run(32'h55, 32'h0, 4'd1, 2'b10, 4'h2, 6'd0);
        check("bad pointer acc", rv, 32'h55);
        flags(32'h100, 32'h100);
        wr(8'h48, 32'h0004);
        run(32'h55, 32'h0, 4'd1, 2'b10, 4'h2, 6'd0);
        check("pointer operand", rv, 32'h54);
        flags(32'h100, 32'h0);
        // Zero flag is left alone by a rejected add
        zf = 1'b0;
        foreach (bA[j]) begin
            bx = bcdExp(bA[j], bB[j], bC[j]);
            if (!bx[33]) zf = (bx[31:0] == 32'h0);
            run(bA[j], bB[j], 4'd7, 2'b00, 4'h0, bC[j]);
            check("bcd sum", rv, bx[33] ? bA[j] : bx[31:0]);
            flags(32'h41, {25'h0, bx[33], 5'h0, zf});
            if (!bx[33]) flags(32'h8, {28'h0, bx[32], 3'b000});
        end
        wr(8'h18, 32'h0);
        rd(8'h14);
        check("status events", rv & 32'hF, 32'hF);
        run(32'h5, 32'h1, 4'd1, 2'b00, 4'h0, 6'd0);
        check("masked irq", {31'h0, irq}, 32'h0);
        wr(8'h18, 32'h01);
        repeat (2) @(posedge core_clk);
        check("irq raised", {31'h0, irq}, 32'h1);
        rd(8'h14);
        check("status done", rv & 32'h1, 32'h1);
        repeat (2) @(posedge core_clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        // Reset again in mid-run: accumulator, stack, flags, status and mask back to zero
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rstAdr[j]) begin
            rd(rstAdr[j]);
            check("reset again", rv, 32'h0);
        end
        check("irq after second reset", {31'h0, irq}, 32'h0);
        conclude();
    end
endmodule : plc_binary_bcd_arith_unit_tb
